// *** logic/operand_field_pkg.sv ***
// Shared types and constants for the operand field decoder
package operand_field_pkg;

	// Word register pair selections
	typedef enum logic [3:0]
	{
		PAIR_BC     = 4'h0,
		PAIR_DE     = 4'h1,
		PAIR_HL     = 4'h2,
		PAIR_SP     = 4'h3,
		PAIR_ALT_BC = 4'h4,
		PAIR_ALT_DE = 4'h5,
		PAIR_ALT_HL = 4'h6,
		PAIR_IX     = 4'h7,
		PAIR_IY     = 4'h8,
		PAIR_AF     = 4'h9,
		PAIR_NONE   = 4'hF
	} word_pair_t;

	// Byte register selections
	typedef enum logic [2:0]
	{
		BYTE_B    = 3'h0,
		BYTE_C    = 3'h1,
		BYTE_D    = 3'h2,
		BYTE_E    = 3'h3,
		BYTE_H    = 3'h4,
		BYTE_L    = 3'h5,
		BYTE_NONE = 3'h6,
		BYTE_A    = 3'h7
	} byte_reg_t;

	// Fetch strobe states for immediate assembly, one-hot
	typedef enum logic [1:0]
	{
		IMM_LOW  = 2'h1,
		IMM_HIGH = 2'h2
	} imm_state_t;

	// Raw opcode fields presented by fetch
	typedef struct packed
	{
		logic [2:0] bit_select;
		logic [1:0] short_condition_field;
		logic [2:0] condition_field;
		logic [1:0] destination_pair_field;
		logic [1:0] alternate_pair_field;
		logic [2:0] byte_register_field;
		logic [1:0] source_pair_field;
		logic [2:0] restart_field;
		logic [1:0] first_index_pair_field;
		logic [1:0] second_index_pair_field;
		logic [1:0] stack_pair_field;
	} op_fields_t;

	// Flag inputs used by condition evaluation
	typedef struct packed
	{
		logic       sign;
		logic       zero;
		logic       carry;
		logic [3:0] result_upper_nibble;
	} cond_flags_t;

	// Decoded selections
	typedef struct packed
	{
		logic [7:0] bit_mask;
		logic       short_condition_true;
		logic       condition_true;
		word_pair_t destination_pair;
		word_pair_t alternate_pair;
		byte_reg_t  byte_register;
		word_pair_t source_pair;
		logic [15:0] restart_vector;
		word_pair_t first_index_pair;
		word_pair_t second_index_pair;
		word_pair_t stack_pair;
	} op_select_t;

	// Reset values and sizes
	localparam logic [15:0] RESTART_NONE  = 16'h0000;
	localparam logic [15:0] RESTART_STEP  = 16'h0010;
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam int          UPPER_NIBBLE_POS = 4;

endpackage

// *** logic/condition_eval.sv ***
// Condition code evaluation for the three-bit condition field
`timescale 1ns/1ps
module condition_eval
(
	input  wire logic [2:0]                   CODE,
	input  wire operand_field_pkg::cond_flags_t FLAGS,
	output logic                              TRUE_OUT
);
	import operand_field_pkg::*;

	logic upper_nibble_zero_condition;
	logic upper_nibble_nonzero_condition;
	logic not_zero_condition;

	assign upper_nibble_zero_condition = (FLAGS.result_upper_nibble == 4'h0);
	assign upper_nibble_nonzero_condition = |FLAGS.result_upper_nibble;
	assign not_zero_condition = ~FLAGS.zero;

	always_comb
	begin
		unique case (CODE)
			3'h0: TRUE_OUT = not_zero_condition;
			3'h1: TRUE_OUT = FLAGS.zero;
			3'h2: TRUE_OUT = ~FLAGS.carry;
			3'h3: TRUE_OUT = FLAGS.carry;
			3'h4: TRUE_OUT = upper_nibble_zero_condition;
			3'h5: TRUE_OUT = upper_nibble_nonzero_condition;
			3'h6: TRUE_OUT = ~FLAGS.sign;
			3'h7: TRUE_OUT = FLAGS.sign;
		endcase
	end
endmodule

// *** logic/operand_field_decoder.sv ***
// Operand field decoder: registered selections and address arithmetic
`timescale 1ns/1ps
module operand_field_decoder
(
	input  wire logic                          CLK,
	input  wire logic                          RST_N,
	input  wire logic                          FIELDS_VALID,
	input  wire operand_field_pkg::op_fields_t FIELDS,
	input  wire operand_field_pkg::cond_flags_t FLAGS,
	input  wire logic                          IMM_BYTE_VALID,
	input  wire logic [7:0]                    IMM_BYTE,
	input  wire logic                          IMM_IS_WORD,
	input  wire logic [7:0]                    DISP_BYTE,
	input  wire logic [15:0]                   INDEX_BASE,
	input  wire logic [15:0]                   PC_BASE,
	output operand_field_pkg::op_select_t      SELECT,
	output logic                               SELECT_VALID,
	output logic                               UNDEFINED_CODE,
	output logic [15:0]                        IMM_VALUE,
	output logic                               IMM_DONE,
	output logic [15:0]                        INDEXED_ADDR,
	output logic [15:0]                        RELATIVE_TARGET
);
	import operand_field_pkg::*;

	// ----------------------------------------------------------------
	// Shared decode functions
	// ----------------------------------------------------------------
	// plain pair decode
	function automatic word_pair_t pair_decode(input logic [1:0] code,
		input word_pair_t third, input word_pair_t fourth);
		word_pair_t p;
		unique case (code)
			2'h0: p = PAIR_BC;
			2'h1: p = PAIR_DE;
			2'h2: p = third;
			2'h3: p = fourth;
		endcase
		return p;
	endfunction

	function automatic logic [15:0] add_signed(input logic [15:0] base,
		input logic [7:0] disp);
		return 16'(base + {{8{disp[7]}}, disp});
	endfunction

	// ----------------------------------------------------------------
	// Combinational decode
	// ----------------------------------------------------------------
	op_select_t sel_d;
	op_select_t sel_q;
	logic       undef_d;
	logic       restart_bad;
	logic       alt_bad;
	logic       byte_bad;
	logic       long_true;

	condition_eval u_cond
	(
		.CODE     (FIELDS.condition_field),
		.FLAGS    (FLAGS),
		.TRUE_OUT (long_true)
	);

	always_comb
	begin
		sel_d = '0;
		sel_d.bit_mask = 8'h01 << FIELDS.bit_select;
		unique case (FIELDS.short_condition_field)
			2'h0: sel_d.short_condition_true = ~FLAGS.zero;
			2'h1: sel_d.short_condition_true = FLAGS.zero;
			2'h2: sel_d.short_condition_true = ~FLAGS.carry;
			2'h3: sel_d.short_condition_true = FLAGS.carry;
		endcase
		sel_d.condition_true = long_true;
		sel_d.destination_pair =
			pair_decode(FIELDS.destination_pair_field, PAIR_HL, PAIR_SP);
		sel_d.alternate_pair = pair_decode(FIELDS.alternate_pair_field,
			PAIR_ALT_HL, PAIR_NONE);
		if (FIELDS.alternate_pair_field == 2'h0)
			sel_d.alternate_pair = PAIR_ALT_BC;
		else if (FIELDS.alternate_pair_field == 2'h1)
			sel_d.alternate_pair = PAIR_ALT_DE;
		sel_d.byte_register = byte_reg_t'(FIELDS.byte_register_field);
		sel_d.source_pair =
			pair_decode(FIELDS.source_pair_field, PAIR_HL, PAIR_SP);
		unique case (FIELDS.restart_field)
			3'h2, 3'h3, 3'h4, 3'h5, 3'h7:
				sel_d.restart_vector =
					16'(RESTART_STEP * FIELDS.restart_field);
			default: sel_d.restart_vector = RESTART_NONE;
		endcase
		sel_d.first_index_pair =
			pair_decode(FIELDS.first_index_pair_field, PAIR_IX, PAIR_SP);
		sel_d.second_index_pair =
			pair_decode(FIELDS.second_index_pair_field, PAIR_IY, PAIR_SP);
		sel_d.stack_pair =
			pair_decode(FIELDS.stack_pair_field, PAIR_HL, PAIR_AF);
	end

	assign restart_bad = (FIELDS.restart_field == 3'h0)
		|| (FIELDS.restart_field == 3'h1)
		|| (FIELDS.restart_field == 3'h6);
	assign alt_bad  = (FIELDS.alternate_pair_field == 2'h3);
	assign byte_bad = (FIELDS.byte_register_field == 3'h6);
	assign undef_d  = restart_bad | alt_bad | byte_bad;

	// ----------------------------------------------------------------
	// Registered selections
	// ----------------------------------------------------------------
	logic sel_valid_q;
	logic undef_q;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sel_q       <= '0;
			sel_valid_q <= 1'b0;
		end
		else
		begin
			sel_valid_q <= FIELDS_VALID;
			if (FIELDS_VALID)
				sel_q <= sel_d;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			undef_q <= 1'b0;
		else
			undef_q <= FIELDS_VALID & undef_d;
	end

	assign SELECT         = sel_q;
	assign SELECT_VALID   = sel_valid_q;
	assign UNDEFINED_CODE = undef_q;

	// ----------------------------------------------------------------
	// Immediate assembly
	// ----------------------------------------------------------------
	imm_state_t  imm_state_q;
	logic [15:0] imm_q;
	logic        imm_done_q;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			imm_state_q <= IMM_LOW;
			imm_q       <= WORD_RESET;
			imm_done_q  <= 1'b0;
		end
		else
		begin
			imm_done_q <= 1'b0;
			if (IMM_BYTE_VALID)
			begin
				unique case (imm_state_q)
					IMM_LOW:
					begin
						imm_q <= {BYTE_RESET, IMM_BYTE};
						if (IMM_IS_WORD)
							imm_state_q <= IMM_HIGH;
						else
							imm_done_q <= 1'b1;
					end
					IMM_HIGH:
					begin
						imm_q[15:8] <= IMM_BYTE;
						imm_state_q <= IMM_LOW;
						imm_done_q  <= 1'b1;
					end
				endcase
			end
		end
	end

	assign IMM_VALUE = imm_q;
	assign IMM_DONE  = imm_done_q;

	// ----------------------------------------------------------------
	// Address arithmetic
	// ----------------------------------------------------------------
	logic [15:0] indexed_q;
	logic [15:0] relative_q;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			indexed_q <= WORD_RESET;
		else
			indexed_q <= add_signed(INDEX_BASE, DISP_BYTE);
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			relative_q <= WORD_RESET;
		else
			relative_q <= add_signed(PC_BASE, DISP_BYTE);
	end

	assign INDEXED_ADDR    = indexed_q;
	assign RELATIVE_TARGET = relative_q;
endmodule

// *** verification/operand_field_sva.sv ***
// Checker for the operand field decoder ports
`timescale 1ns/1ps
module operand_field_sva
(
	input wire logic			CLK,
	input wire logic			RST_N,
	input wire logic			FIELDS_VALID,
	input wire operand_field_pkg::op_fields_t	FIELDS,
	input wire operand_field_pkg::cond_flags_t	FLAGS,
	input wire logic			IMM_BYTE_VALID,
	input wire logic [7:0]			IMM_BYTE,
	input wire logic			IMM_IS_WORD,
	input wire logic [7:0]			DISP_BYTE,
	input wire logic [15:0]			INDEX_BASE,
	input wire logic [15:0]			PC_BASE,
	input wire operand_field_pkg::op_select_t	SELECT,
	input wire logic			SELECT_VALID,
	input wire logic			UNDEFINED_CODE,
	input wire logic [15:0]			IMM_VALUE,
	input wire logic			IMM_DONE,
	input wire logic [15:0]			INDEXED_ADDR,
	input wire logic [15:0]			RELATIVE_TARGET
);
	import operand_field_pkg::*;
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	function automatic logic cond(input logic [2:0] c, input cond_flags_t f);
		case (c)
			3'h0: cond = !f.zero;
			3'h1: cond = f.zero;
			3'h2: cond = !f.carry;
			3'h3: cond = f.carry;
			3'h4: cond = f.result_upper_nibble == 4'h0;
			3'h5: cond = f.result_upper_nibble != 4'h0;
			3'h6: cond = !f.sign;
			default: cond = f.sign;
		endcase
	endfunction
	sequence word_s;
		IMM_BYTE_VALID && IMM_IS_WORD ##1 IMM_BYTE_VALID;
	endsequence
	AST_BIT: assert property (
		SELECT_VALID |-> SELECT.bit_mask ==
		8'h01 << $past(FIELDS.bit_select)) else $error("bit mask wrong");
	AST_COND: assert property (
		SELECT_VALID |-> SELECT.condition_true ==
		cond($past(FIELDS.condition_field), $past(FLAGS)))
		else $error("condition wrong");
	AST_SHORT: assert property (
		SELECT_VALID |-> SELECT.short_condition_true ==
		cond({1'b0, $past(FIELDS.short_condition_field)}, $past(FLAGS)))
		else $error("short condition wrong");
	AST_DEST: assert property (
		SELECT_VALID |-> SELECT.destination_pair ==
		$past(FIELDS.destination_pair_field)) else $error("pair wrong");
	AST_UNDEF: assert property (
		SELECT_VALID |-> UNDEFINED_CODE ==
		($past(FIELDS.alternate_pair_field) == 2'h3 ||
		$past(FIELDS.byte_register_field) == 3'h6 ||
		$past(FIELDS.restart_field) inside {3'h0, 3'h1, 3'h6}))
		else $error("undefined flag wrong");
	AST_RST: assert property (
		SELECT_VALID && !UNDEFINED_CODE |-> SELECT.restart_vector ==
		{9'h000, $past(FIELDS.restart_field), 4'h0})
		else $error("restart vector wrong");
	AST_IMM: assert property (
		word_s |=> IMM_DONE &&
		IMM_VALUE == {$past(IMM_BYTE), $past(IMM_BYTE, 2)})
		else $error("immediate word wrong");
	AST_REL: assert property (
		$past(RST_N) |-> RELATIVE_TARGET == $past(PC_BASE) +
		{{8{$past(DISP_BYTE[7])}}, $past(DISP_BYTE)})
		else $error("relative target wrong");
	AST_IDX: assert property (
		$past(RST_N) |-> INDEXED_ADDR == $past(INDEX_BASE) +
		{{8{$past(DISP_BYTE[7])}}, $past(DISP_BYTE)})
		else $error("indexed address wrong");
	AST_HOLD: assert property (
		!FIELDS_VALID |=> !SELECT_VALID && $stable(SELECT))
		else $error("selection changed");
endmodule

bind operand_field_decoder operand_field_sva chk
(
	.CLK(CLK), .RST_N(RST_N), .FIELDS_VALID(FIELDS_VALID),
	.FIELDS(FIELDS), .FLAGS(FLAGS), .IMM_BYTE_VALID(IMM_BYTE_VALID),
	.IMM_BYTE(IMM_BYTE), .IMM_IS_WORD(IMM_IS_WORD), .DISP_BYTE(DISP_BYTE),
	.INDEX_BASE(INDEX_BASE), .PC_BASE(PC_BASE), .SELECT(SELECT),
	.SELECT_VALID(SELECT_VALID), .UNDEFINED_CODE(UNDEFINED_CODE),
	.IMM_VALUE(IMM_VALUE), .IMM_DONE(IMM_DONE),
	.INDEXED_ADDR(INDEXED_ADDR), .RELATIVE_TARGET(RELATIVE_TARGET)
);

// *** verification/fetch_model.sv ***
// Fetch-side model presenting immediate bytes
`timescale 1ns/1ps
module fetch_model
(
	input wire logic	CLK,
	output logic		IMM_BYTE_VALID,
	output logic [7:0]	IMM_BYTE,
	output logic		IMM_IS_WORD
);
	initial
	begin
		IMM_BYTE_VALID = 1'b0;
		IMM_BYTE = 8'h5A;
		IMM_IS_WORD = 1'b0;
	end
	task automatic put(input logic [15:0] w, input logic wd);
		@(posedge CLK);
		IMM_BYTE_VALID <= 1'b1;
		IMM_BYTE <= w[7:0];
		IMM_IS_WORD <= wd;
		if (wd)
		begin
			@(posedge CLK);
			IMM_BYTE <= w[15:8];
			IMM_IS_WORD <= 1'b0;
		end
		@(posedge CLK);
		IMM_BYTE_VALID <= 1'b0;
		IMM_BYTE <= ~IMM_BYTE;
	endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
module testbench;
	import operand_field_pkg::*;
	// ----------------
	// Signals
	// ----------------
	typedef struct packed
	{
		logic [2:0]	code;
		cond_flags_t	flags;
		logic [1:0]	exp;
	} row_t;
	localparam row_t ROWS [11] = '{
		{3'h0, 7'h00, 2'h3}, {3'h1, 7'h00, 2'h0}, {3'h2, 7'h10, 2'h0},
		{3'h3, 7'h10, 2'h3}, {3'h4, 7'h20, 2'h2}, {3'h5, 7'h01, 2'h2},
		{3'h6, 7'h00, 2'h3}, {3'h7, 7'h00, 2'h0}, {3'h4, 7'h08, 2'h1},
		{3'h5, 7'h20, 2'h1}, {3'h6, 7'h50, 2'h0}};
	logic		CLK = 1'b0;
	logic		RST_N = 1'b0;
	logic		FIELDS_VALID = 1'b0;
	op_fields_t	FIELDS = '0;
	cond_flags_t	FLAGS = '0;
	logic [7:0]	DISP_BYTE = 8'h00;
	logic [15:0]	INDEX_BASE = 16'h0000;
	logic [15:0]	PC_BASE = 16'h0000;
	logic		imm_v, imm_w, SELECT_VALID, UNDEFINED_CODE, IMM_DONE;
	logic [7:0]	imm_b;
	op_select_t	SELECT;
	logic [15:0]	IMM_VALUE, INDEXED_ADDR, RELATIVE_TARGET;
	logic [2:0]	c;
	int		n_fail = 0;
	int		checked = 0;
	int		cyc = 0;
	initial forever #10 CLK = ~CLK;
	fetch_model fetch (.CLK(CLK), .IMM_BYTE_VALID(imm_v), .IMM_BYTE(imm_b),
		.IMM_IS_WORD(imm_w));
	operand_field_decoder dut
	(
		.CLK(CLK), .RST_N(RST_N), .FIELDS_VALID(FIELDS_VALID),
		.FIELDS(FIELDS), .FLAGS(FLAGS), .IMM_BYTE_VALID(imm_v),
		.IMM_BYTE(imm_b), .IMM_IS_WORD(imm_w), .DISP_BYTE(DISP_BYTE),
		.INDEX_BASE(INDEX_BASE), .PC_BASE(PC_BASE), .SELECT(SELECT),
		.SELECT_VALID(SELECT_VALID), .UNDEFINED_CODE(UNDEFINED_CODE),
		.IMM_VALUE(IMM_VALUE), .IMM_DONE(IMM_DONE),
		.INDEXED_ADDR(INDEXED_ADDR), .RELATIVE_TARGET(RELATIVE_TARGET)
	);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic adder(input logic [7:0] d, input logic [15:0] p, x, ep, ex);
		@(posedge CLK);
		DISP_BYTE <= d;
		PC_BASE <= p;
		INDEX_BASE <= x;
		@(posedge CLK);
		#1;
		chk(RELATIVE_TARGET, ep);
		chk(INDEXED_ADDR, ex);
	endtask
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ----------------
	// Sequence
	// ----------------
	initial
	begin
		repeat (2) @(posedge CLK);
		#1;
		chk(UNDEFINED_CODE, 1'b0);
		@(posedge CLK);
		RST_N <= 1'b1;
		foreach (ROWS[i])
		begin
			c = ROWS[i].code;
			@(posedge CLK);
			FIELDS_VALID <= 1'b1;
			FIELDS <= '{c, c[1:0], c, c[1:0], c[1:0], c, c[1:0], c,
				c[1:0], c[1:0], c[1:0]};
			FLAGS <= ROWS[i].flags;
			@(posedge CLK);
			#1;
			chk(SELECT_VALID, 1'b1);
			chk(SELECT.bit_mask, 8'h01 << c);
			chk({SELECT.condition_true, SELECT.short_condition_true},
				ROWS[i].exp);
			chk(SELECT.destination_pair, c[1:0]);
			chk(SELECT.source_pair, c[1:0]);
			chk(SELECT.alternate_pair, c[1:0] == 2'h3 ? 4'hF : c[1:0] + 4'h4);
			chk(SELECT.first_index_pair, c[1:0] == 2'h2 ? PAIR_IX : c[1:0]);
			chk(SELECT.second_index_pair, c[1:0] == 2'h2 ? PAIR_IY : c[1:0]);
			chk(SELECT.stack_pair, c[1:0] == 2'h3 ? PAIR_AF : c[1:0]);
			chk(SELECT.byte_register, c);
			chk(SELECT.restart_vector, c inside {3'h0, 3'h1, 3'h6} ?
				16'h0000 : {9'h000, c, 4'h0});
			chk(UNDEFINED_CODE, c inside {3'h0, 3'h1, 3'h6} || c[1:0] == 2'h3);
		end
		FIELDS_VALID <= 1'b0;
		FIELDS.restart_field <= 3'h2;
		repeat (2) @(posedge CLK);
		#1;
		chk(SELECT.restart_vector, 16'h0000);
		chk(UNDEFINED_CODE, 1'b0);
		fetch.put(16'h1234, 1'b1);
		#1;
		chk({IMM_DONE, IMM_VALUE}, 17'h11234);
		fetch.put(16'h00A5, 1'b0);
		#1;
		chk({IMM_DONE, IMM_VALUE}, 17'h100A5);
		adder(8'h80, 16'h0100, 16'h0010, 16'h0080, 16'hFF90);
		adder(8'h7F, 16'hFFF0, 16'h0010, 16'h006F, 16'h008F);
		RST_N = 1'b0;
		#1;
		chk(SELECT.restart_vector, 16'h0000);
		tally_and_finish();
	end
endmodule
